// ---- verilog/asrc_ctrl.sv ----
/*
 * host controller for a 1M x 16 asynchronous static ram with two chip
 * selects and two byte-lane selects. a user request port issues single
 * reads and strobe-closed writes.
 * assumes the ram pins are wired directly; the data bus is split into
 * in, out and output enable, resolved by the board or testbench.
 */
// Summary of operation
// - write ends at first deassertion; we end it by the strobe
// - hold write data stable around the terminating strobe edge
// - wait 100 us after power before the first access
// - strobe-closed write with drive enable low lasts float delay plus setup
// - address-driven read keeps selects, drive enable low, strobe high
// - address valid no later than chip selection becomes active
`timescale 1ns/1ps
`include "asrc_defines.svh"

module asrc_ctrl (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [`ASRC_ADDR_W-1:0] req_addr,
    input wire logic [`ASRC_DATA_W-1:0] req_wdata,
    input wire logic [1:0] req_byte_en,
    output logic rsp_valid,
    output logic [`ASRC_DATA_W-1:0] rsp_rdata,
    output logic ram_ready,
    output logic [`ASRC_ADDR_W-1:0] mem_addr,
    output logic chip_select_low_n,
    output logic chip_select_high,
    output logic output_drive_n,
    output logic write_strobe_n,
    output logic lower_byte_select_n,
    output logic upper_byte_select_n,
    input wire logic [`ASRC_DATA_W-1:0] data_in,
    output logic [`ASRC_DATA_W-1:0] data_out,
    output logic data_oe
);
    logic [`ASRC_CNT_W-1:0] wait_val;
    logic wait_load;
    logic wait_done;
    logic pu_load_q;

    // ----------------------------------------
    // sequencer state
    // ----------------------------------------
    asrc_pkg::asrc_state_t state_q, state_d;
    logic [`ASRC_ADDR_W-1:0] addr_q, addr_d;
    logic [`ASRC_DATA_W-1:0] wdata_q, wdata_d;
    logic [`ASRC_DATA_W-1:0] rdata_q, rdata_d;
    logic [1:0] be_q, be_d;
    logic sel_q, sel_d;
    logic oe_n_q, oe_n_d;
    logic we_n_q, we_n_d;
    logic drive_q, drive_d;
    logic rsp_q, rsp_d;
    logic ready_q, ready_d;

    function automatic logic [`ASRC_CNT_W-1:0] asrc_cnt(input int cycles);
        asrc_cnt = `ASRC_CNT_W'(cycles - 1);
    endfunction

    asrc_wait u_wait (
        .clk(clk),
        .nrst(nrst),
        .ce(clk_en),
        .load(wait_load),
        .value(wait_val),
        .done(wait_done)
    );

    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        be_d = be_q;
        sel_d = sel_q;
        oe_n_d = oe_n_q;
        we_n_d = we_n_q;
        drive_d = drive_q;
        rsp_d = 1'b0;
        ready_d = ready_q;
        wait_load = 1'b0;
        wait_val = '0;
        unique case (state_q)
            asrc_pkg::ST_POWER_UP: begin
                // no access before the supply settle time has passed
                if (pu_load_q) begin
                    wait_load = 1'b1;
                    wait_val = asrc_cnt(`ASRC_POWER_UP_WAIT_CYC);
                end else if (wait_done) begin
                    ready_d = 1'b1;
                    state_d = asrc_pkg::ST_IDLE;
                end
            end
            asrc_pkg::ST_IDLE: begin
                // a request waits while the bus of the last write is still held
                if (req_valid && req_ready) begin
                    // address, lanes and select all latched now, at the same edge
                    addr_d = req_addr;
                    wdata_d = req_wdata;
                    be_d = req_byte_en;
                    if (req_write) begin
                        oe_n_d = 1'b1;
                        state_d = asrc_pkg::ST_WRITE;
                    end else begin
                        // selected, drive enable low, strobe high for the read
                        oe_n_d = 1'b0;
                        wait_load = 1'b1;
                        wait_val = asrc_cnt(`ASRC_RD_WAIT_CYC + 1);
                        state_d = asrc_pkg::ST_READ;
                    end
                    sel_d = 1'b1;
                end
            end
            asrc_pkg::ST_READ: begin
                if (wait_done) begin
                    rdata_d = data_in;
                    rsp_d = 1'b1;
                    sel_d = 1'b0;
                    oe_n_d = 1'b1;
                    state_d = asrc_pkg::ST_IDLE;
                end
            end
            asrc_pkg::ST_WRITE: begin
                // strobe falls in the same cycle the data drive starts; selects held
                we_n_d = 1'b0;
                drive_d = 1'b1;
                wait_load = 1'b1;
                // strobe low long enough for float delay plus data setup
                wait_val = asrc_cnt(`ASRC_WR_LOW_CYC);
                state_d = asrc_pkg::ST_WRITE_END;
            end
            asrc_pkg::ST_WRITE_END: begin
                if (wait_done) begin
                    // strobe closes the write; selects and data stay one more cycle
                    we_n_d = 1'b1;
                    rsp_d = 1'b1;
                    state_d = asrc_pkg::ST_IDLE;
                end
            end
        endcase
        // release bus and selects a cycle after the strobe rose
        if (state_q == asrc_pkg::ST_IDLE && we_n_q) begin
            drive_d = 1'b0;
            if (!(req_valid && req_ready)) begin
                sel_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= asrc_pkg::ST_POWER_UP;
            addr_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            be_q <= '0;
            sel_q <= 1'b0;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            drive_q <= 1'b0;
            rsp_q <= 1'b0;
            ready_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            be_q <= be_d;
            sel_q <= sel_d;
            oe_n_q <= oe_n_d;
            we_n_q <= we_n_d;
            drive_q <= drive_d;
            rsp_q <= rsp_d;
            ready_q <= ready_d;
        end
    end

    // the power-up wait is loaded once, right after reset release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pu_load_q <= 1'b1;
        end else if (clk_en) begin
            pu_load_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // pins
    // ----------------------------------------
    assign req_ready = ready_q && (state_q == asrc_pkg::ST_IDLE) && !drive_q;
    assign rsp_valid = rsp_q;
    assign rsp_rdata = rdata_q;
    assign ram_ready = ready_q;
    assign mem_addr = addr_q;
    assign chip_select_low_n = !sel_q;
    assign chip_select_high = sel_q;
    assign output_drive_n = oe_n_q;
    assign write_strobe_n = we_n_q;
    // lanes selected only while in an access, each by its enable
    assign lower_byte_select_n = !(sel_q && be_q[0]);
    assign upper_byte_select_n = !(sel_q && be_q[1]);
    assign data_out = wdata_q;
    // never drive while the ram may drive: drive is gated off while output_drive_n is low
    assign data_oe = drive_q && oe_n_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [`ASRC_CNT_W-1:0] pu_cnt_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pu_cnt_q <= '0;
        end else if (clk_en && !ready_q) begin
            pu_cnt_q <= pu_cnt_q + 1'b1;
        end
    end

    // strobe low time in enabled cycles, judged at the strobe rise
    logic [`ASRC_CNT_W-1:0] wr_low_cnt_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_low_cnt_q <= '0;
        end else if (clk_en) begin
            wr_low_cnt_q <= write_strobe_n ? '0 : wr_low_cnt_q + 1'b1;
        end
    end

    a_no_early_access: assert property (@(posedge clk) disable iff (!nrst)
        $rose(ready_q) |-> pu_cnt_q >= `ASRC_CNT_W'(`ASRC_POWER_UP_WAIT_CYC - 1))
        else $error("access enabled before power-up wait");
    a_write_overlap: assert property (@(posedge clk) disable iff (!nrst)
        !write_strobe_n |-> (sel_q && output_drive_n && data_oe))
        else $error("write strobe low outside a selected, driven write");
    a_data_hold_end: assert property (@(posedge clk) disable iff (!nrst)
        (clk_en && $rose(write_strobe_n)) |-> (data_oe && !chip_select_low_n
            && $stable(data_out)))
        else $error("write data or select changed at strobe rise");
    a_strobe_width: assert property (@(posedge clk) disable iff (!nrst)
        $rose(write_strobe_n) |-> wr_low_cnt_q >= `ASRC_CNT_W'(`ASRC_WR_LOW_CYC))
        else $error("write strobe pulse too short");
    a_read_steady: assert property (@(posedge clk) disable iff (!nrst)
        (state_q == asrc_pkg::ST_READ) |-> (!output_drive_n && write_strobe_n
            && chip_select_high && !data_oe))
        else $error("read cycle not held steady");
    a_addr_first: assert property (@(posedge clk) disable iff (!nrst)
        (chip_select_high && $past(chip_select_high)) |-> $stable(mem_addr))
        else $error("address changed after selection");
    a_no_bus_fight: assert property (@(posedge clk) disable iff (!nrst)
        !output_drive_n |-> !data_oe)
        else $error("host drives bus while ram outputs enabled");
    a_sel_pair: assert property (@(posedge clk) disable iff (!nrst)
        chip_select_high == !chip_select_low_n)
        else $error("chip selects disagree");
    a_strobe_ends: assert property (@(posedge clk) disable iff (!nrst)
        $rose(write_strobe_n) |-> (chip_select_high && $stable(lower_byte_select_n)
            && $stable(upper_byte_select_n)))
        else $error("write not closed by strobe");
endmodule

// ---- verilog/asrc_defines.svh ----
/*
 * constants for the asynchronous sram host controller: pin widths, timing
 * figures and the cycle counts derived from them.
 * assumes a 100 MHz controller clock.
 */
`ifndef ASRC_DEFINES_SVH
`define ASRC_DEFINES_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define ASRC_ADDR_W 20
`define ASRC_DATA_W 16
`define ASRC_BYTE_W 8

// ----------------------------------------
// timing
// ----------------------------------------
`define ASRC_CLK_PERIOD_NS 10
`define ASRC_POWER_UP_WAIT_US 100
`define ASRC_POWER_UP_WAIT_CYC ((`ASRC_POWER_UP_WAIT_US * 1000 + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_WRITE_STROBE_TO_FLOAT_DELAY_NS 5
`define ASRC_WRITE_DATA_SETUP_NS 5
// strobe low cycles: float delay plus data setup, rounded up
`define ASRC_WR_LOW_CYC ((`ASRC_WRITE_STROBE_TO_FLOAT_DELAY_NS + `ASRC_WRITE_DATA_SETUP_NS + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_ACCESS_NS 10
`define ASRC_RD_WAIT_CYC ((`ASRC_ACCESS_NS + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_CNT_W 14

`endif

// ---- verilog/asrc_pkg.sv ----
/*
 * types for the asynchronous sram host controller.
 * assumes asrc_defines.svh is compiled alongside.
 */
package asrc_pkg;
    typedef enum logic [2:0] {
        ST_POWER_UP,
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_WRITE_END
    } asrc_state_t;
endpackage

// ---- verilog/asrc_wait.sv ----
/*
 * down counter used for every timed wait of the controller.
 * assumes load and enable come from the same clock domain.
 */
`timescale 1ns/1ps
`include "asrc_defines.svh"

module asrc_wait (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic load,
    input wire logic [`ASRC_CNT_W-1:0] value,
    output logic done
);
    logic [`ASRC_CNT_W-1:0] cnt_q;
    logic [`ASRC_CNT_W-1:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = value;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else if (ce) begin
            cnt_q <= cnt_d;
        end
    end

    assign done = (cnt_q == '0) && !load;
endmodule

// ---- testbench/asrc_ram_model.sv ----
/*
 * behavioural model of the 1M x 16 sram seen on the controller pins.
 * assumes the bench resolves the shared data bus and feeds it to dq_in.
 */
`timescale 1ns/1ps
`include "asrc_defines.svh"

module asrc_ram_model (
    input wire logic [`ASRC_ADDR_W-1:0] mem_addr,
    input wire logic chip_select_low_n,
    input wire logic chip_select_high,
    input wire logic output_drive_n,
    input wire logic write_strobe_n,
    input wire logic lower_byte_select_n,
    input wire logic upper_byte_select_n,
    input wire logic data_oe,
    input wire logic [`ASRC_DATA_W-1:0] dq_in,
    output logic [`ASRC_DATA_W-1:0] dq_out,
    output logic [1:0] dq_oe,
    output logic fault
);
    // ----------------------------------------
    // array and decode
    // ----------------------------------------
    logic [`ASRC_DATA_W-1:0] mem [logic [`ASRC_ADDR_W-1:0]];
    logic sel;
    logic [1:0] lane;
    logic [1:0] wr;
    logic [1:0] wr_q = 2'b00;
    logic [`ASRC_DATA_W-1:0] word;

    assign sel = !chip_select_low_n && chip_select_high;
    assign lane = {!upper_byte_select_n, !lower_byte_select_n};
    assign wr = {2{sel && !write_strobe_n}} & lane;
    assign dq_oe = {2{sel && !output_drive_n && write_strobe_n}} & lane;
    // unwritten words read as a pattern, so a zero default cannot hide a lost write
    // wr_q settles after every array update, so a read at the written address refreshes
    always @(mem_addr or wr_q) dq_out = mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr[15:0];

    // ----------------------------------------
    // write, taken at the edge that ends it
    // ----------------------------------------
    always @(wr) begin
        word = mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr[15:0];
        if (wr_q[0] && !wr[0])
            word[7:0] = dq_in[7:0];
        if (wr_q[1] && !wr[1])
            word[15:8] = dq_in[15:8];
        if (wr_q != 2'b00)
            mem[mem_addr] = word;
        wr_q = wr;
    end

    // ----------------------------------------
    // misuse seen on the pins
    // ----------------------------------------
    logic early_sel = 1'b0;
    logic addr_moved = 1'b0;
    logic bus_fight = 1'b0;

    assign fault = early_sel || addr_moved || bus_fight;
    always @(posedge sel)
        if ($realtime < 100us)
            early_sel = 1'b1;
    always @(mem_addr)
        if (wr != 2'b00)
            addr_moved = 1'b1;
    always @*
        if (dq_oe != 2'b00 && data_oe === 1'b1)
            bus_fight = 1'b1;
endmodule

// ---- testbench/test_async_sram_16bit_byte_lane_port.sv ----
/*
 * testbench for asrc_ctrl driving the sram model: power-up, lane writes
 * and reads, address limits and clock-enable stalls.
 * assumes a 100 MHz clock and asrc_ram_model compiled first.
 */
`timescale 1ns/1ps
`include "asrc_defines.svh"

module test_async_sram_16bit_byte_lane_port;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [`ASRC_ADDR_W-1:0] req_addr = 20'h00000;
    logic [`ASRC_DATA_W-1:0] req_wdata = 16'h0000;
    logic [1:0] req_byte_en = 2'b00;
    logic req_ready, rsp_valid, ram_ready, chip_select_low_n, chip_select_high;
    logic output_drive_n, write_strobe_n, lower_byte_select_n, upper_byte_select_n;
    logic data_oe, fault;
    logic [1:0] dq_oe;
    logic [`ASRC_ADDR_W-1:0] mem_addr;
    logic [`ASRC_DATA_W-1:0] rsp_rdata, data_out, dq_out, bus, q;
    logic [`ASRC_DATA_W-1:0] float_pat = 16'hA53C;
    int lat;
    int err_count = 0;
    int checked = 0;

    always #5 clk = ~clk;
    // a released lane shows a changing pattern so stale data cannot pass
    always @(posedge clk) float_pat <= ~float_pat;
    assign bus[7:0] = data_oe ? data_out[7:0] : dq_oe[0] ? dq_out[7:0] : float_pat[7:0];
    assign bus[15:8] = data_oe ? data_out[15:8] : dq_oe[1] ? dq_out[15:8] : float_pat[15:8];

    asrc_ctrl u_asrc_ctrl (.clk, .nrst, .clk_en, .req_valid, .req_ready, .req_write,
        .req_addr, .req_wdata, .req_byte_en, .rsp_valid, .rsp_rdata, .ram_ready,
        .mem_addr, .chip_select_low_n, .chip_select_high, .output_drive_n,
        .write_strobe_n, .lower_byte_select_n, .upper_byte_select_n,
        .data_in(bus), .data_out, .data_oe);
    asrc_ram_model u_asrc_ram_model (.mem_addr, .chip_select_low_n, .chip_select_high,
        .output_drive_n, .write_strobe_n, .lower_byte_select_n, .upper_byte_select_n,
        .data_oe, .dq_in(bus), .dq_out, .dq_oe, .fault);

    // ----------------------------------------
    // report and request helpers
    // ----------------------------------------
    task automatic finish_test();
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic timeout();
        err_count++;
        finish_test();
    endtask

    task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // entered at a falling edge; clk_en is held low for stall cycles after the take
    task automatic access(input logic w, input logic [19:0] a, input logic [15:0] d,
            input logic [1:0] be, input int stall);
        int n;
        n = 0;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        req_byte_en = be;
        req_valid = 1'b1;
        while (req_ready !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 20000)
                timeout();
        end
        @(posedge clk);
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (n == 1)
                req_valid = 1'b0;
            clk_en = (n > stall);
            if (n > 50)
                timeout();
        end while (rsp_valid !== 1'b1);
        q = rsp_rdata;
        lat = n;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_power_up();
        int n;
        int early;
        n = 0;
        early = 0;
        repeat (16) @(negedge clk);
        check_val("reset_pins", 16'h00B0, {8'h00, chip_select_low_n, chip_select_high,
            output_drive_n, write_strobe_n, data_oe, req_ready, ram_ready, rsp_valid});
        nrst = 1'b1;
        req_valid = 1'b1;
        while (ram_ready !== 1'b1 && n < 12000) begin
            @(negedge clk);
            n++;
            if ((req_ready === 1'b1 || chip_select_high === 1'b1) && ram_ready !== 1'b1)
                early++;
        end
        req_valid = 1'b0;
        check_val("early_ready", 16'h0000, 16'(early));
        check_val("power_up_wait", 16'h0001, 16'(n >= `ASRC_POWER_UP_WAIT_CYC - 1
            && n <= `ASRC_POWER_UP_WAIT_CYC + 2));
    endtask

    task automatic t_lanes();
        access(1'b1, 20'h12345, 16'h1234, 2'b11, 0);
        check_val("write_latency", 16'h0003, 16'(lat));
        access(1'b1, 20'h12345, 16'hFFAB, 2'b01, 0);
        access(1'b1, 20'h12345, 16'hCD00, 2'b10, 0);
        access(1'b1, 20'h12345, 16'h0000, 2'b00, 0);
        access(1'b0, 20'h12345, 16'h0000, 2'b11, 0);
        check_val("word", 16'hCDAB, q);
        check_val("read_latency", 16'h0003, 16'(lat));
        access(1'b0, 20'h12345, 16'h0000, 2'b01, 0);
        check_val("lower_lane", 16'h00AB, {8'h00, q[7:0]});
        access(1'b0, 20'h12345, 16'h0000, 2'b10, 0);
        check_val("upper_lane", 16'h00CD, {8'h00, q[15:8]});
    endtask

    task automatic t_limits();
        access(1'b1, 20'hFFFFF, 16'h5A5A, 2'b11, 0);
        access(1'b1, 20'h00000, 16'hA5A5, 2'b11, 0);
        access(1'b0, 20'hFFFFF, 16'h0000, 2'b11, 0);
        check_val("top_word", 16'h5A5A, q);
        access(1'b0, 20'h00000, 16'h0000, 2'b11, 0);
        check_val("bottom_word", 16'hA5A5, q);
    endtask

    task automatic t_stall();
        access(1'b0, 20'h00000, 16'h0000, 2'b11, 4);
        check_val("stalled_read", 16'hA5A5, q);
        check_val("stalled_read_latency", 16'h0007, 16'(lat));
        access(1'b1, 20'h00001, 16'h0F0F, 2'b11, 3);
        check_val("stalled_write_latency", 16'h0006, 16'(lat));
        access(1'b0, 20'h00001, 16'h0000, 2'b11, 0);
        check_val("stalled_word", 16'h0F0F, q);
        check_val("model_fault", 16'h0000, {15'h0000, fault});
    endtask

    initial begin
        t_power_up();
        t_lanes();
        t_limits();
        t_stall();
        finish_test();
    end
endmodule
